/* tw_pkg.sv */
// shared constants, state type and the two-flop synchroniser of the serial slave
`timescale 1ns/10ps
package tw_pkg;
    localparam int       TW_DW        = 8;
    localparam int       TW_AW        = 5;
    localparam int       TW_NUM_REGS  = 30;
    localparam logic [4:0] TW_REG_TOP = 5'h1d;
    localparam logic [7:0] TW_REG_TOP_BYTE = 8'h1d;
    localparam logic [4:0] TW_ADDR_HI = 5'h13;
    localparam logic [3:0] TW_BYTE_BITS = 4'h8;
    localparam logic [3:0] TW_LAST_TX_BIT = 4'h7;
    localparam logic [7:0] TW_REG_RESET = 8'h00;

    typedef enum logic [3:0] {
        TW_IDLE,
        TW_ADDR,
        TW_A_ACK,
        TW_REGA,
        TW_R_ACK,
        TW_WDATA,
        TW_W_ACK,
        TW_RDATA,
        TW_RACK_CHK,
        TW_RACK_OK,
        TW_WAIT_STOP
    } tw_state_t;
endpackage

module tw_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i) begin
        meta_r <= d_i;
        q_o    <= meta_r;
    end
endmodule

/* tw_slave.sv */
// two-wire register access slave: serial engine on the link clock, write events to clk_i
`timescale 1ns/10ps
// Overview of operation
// - bytes move most significant bit first
// - refused write byte leaves data released high
// - master nack on read ends data, release
// - first byte to base, then address plus one
// - address saturates at top register 1dh
// - register address above 1dh is not acknowledged
// - read starts at address set by write
// - read advances address after each byte
// - stop ends transfer, data rising clock high
// - repeated start begins a new transfer
// - start is data falling while clock high
// - first byte: seven address bits, direction
// - acknowledge address only on match with pins
module tw_slave (
    input  wire logic                     clk_i,
    input  wire logic                     rst_b_i,
    input  wire logic                     link_clk_i,
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    output logic                          sda_o,
    output logic                          sda_oe_o,
    input  wire logic [1:0]               device_address_select_pins_i,
    output logic                          reg_wr_stb_o,
    output logic [tw_pkg::TW_AW-1:0]      reg_wr_addr_o,
    output logic [tw_pkg::TW_DW-1:0]      reg_wr_data_o
);
    import tw_pkg::*;

    function automatic logic [TW_AW-1:0] sat_inc(input logic [TW_AW-1:0] p);
        sat_inc = (p == TW_REG_TOP) ? p : p + 5'h01;
    endfunction

    logic                 lrst_b;
    logic [4:0]           pins_s;
    logic                 scl_s;
    logic                 sda_s;
    logic [1:0]           sel_s;
    logic                 scl_q;
    logic                 sda_q;
    logic                 start;
    logic                 stop;
    logic                 scl_rise;
    logic                 scl_fall;
    tw_state_t            st_r;
    logic [3:0]           cnt_r;
    logic [TW_DW-1:0]     shift_r;
    logic                 ack_r;
    logic                 rw_r;
    logic [TW_AW-1:0]     ptr_r;
    logic [TW_DW-1:0]     regs_r [TW_NUM_REGS];
    logic [TW_AW-1:0]     wr_addr_l_r;
    logic [TW_DW-1:0]     wr_data_l_r;
    logic                 wr_tgl_l_r;
    logic                 wr_tgl_s;
    logic                 wr_tgl_q_r;
    logic                 addr_match;

    tw_sync2 #(.W(5)) u_sync_link (
        .clk_i (link_clk_i),
        .d_i   ({rst_b_i, scl_i, sda_i, device_address_select_pins_i}),
        .q_o   (pins_s)
    );

    assign lrst_b = pins_s[4];
    assign scl_s  = pins_s[3];
    assign sda_s  = pins_s[2];
    assign sel_s  = pins_s[1:0];

    always_ff @(posedge link_clk_i) begin
        if (!lrst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign start    = scl_s & scl_q & sda_q & ~sda_s;
    assign stop     = scl_s & scl_q & ~sda_q & sda_s;
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign addr_match = (shift_r[7:1] == {TW_ADDR_HI, sel_s});

    always_ff @(posedge link_clk_i) begin
        if (!lrst_b) begin
            st_r        <= TW_IDLE;
            cnt_r       <= 4'h0;
            shift_r     <= 8'h00;
            ack_r       <= 1'b0;
            rw_r        <= 1'b0;
            ptr_r       <= 5'h00;
            wr_addr_l_r <= 5'h00;
            wr_data_l_r <= 8'h00;
            wr_tgl_l_r  <= 1'b0;
            for (int i = 0; i < TW_NUM_REGS; i++) begin
                regs_r[i] <= TW_REG_RESET;
            end
        end else if (stop) begin
            st_r <= TW_IDLE;
        end else if (start) begin
            st_r  <= TW_ADDR;
            cnt_r <= 4'h0;
        end else begin
            unique case (st_r)
                TW_IDLE, TW_WAIT_STOP: begin
                end
                TW_ADDR, TW_REGA, TW_WDATA: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s};
                        cnt_r   <= cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == TW_BYTE_BITS) begin
                        cnt_r <= 4'h0;
                        if (st_r == TW_ADDR) begin
                            ack_r <= addr_match;
                            rw_r  <= shift_r[0];
                            st_r  <= TW_A_ACK;
                        end else if (st_r == TW_REGA) begin
                            ack_r <= (shift_r <= TW_REG_TOP_BYTE);
                            if (shift_r <= TW_REG_TOP_BYTE) begin
                                ptr_r <= shift_r[4:0];
                            end
                            st_r <= TW_R_ACK;
                        end else begin
                            ack_r             <= 1'b1;
                            regs_r[ptr_r]     <= shift_r;
                            ptr_r             <= sat_inc(ptr_r);
                            wr_addr_l_r       <= ptr_r;
                            wr_data_l_r       <= shift_r;
                            wr_tgl_l_r        <= ~wr_tgl_l_r;
                            st_r              <= TW_W_ACK;
                        end
                    end
                end
                TW_A_ACK: begin
                    if (scl_fall) begin
                        if (!ack_r) begin
                            st_r <= TW_WAIT_STOP;
                        end else if (rw_r) begin
                            st_r    <= TW_RDATA;
                            shift_r <= regs_r[ptr_r];
                            cnt_r   <= 4'h0;
                        end else begin
                            st_r <= TW_REGA;
                        end
                    end
                end
                TW_R_ACK: begin
                    if (scl_fall) begin
                        st_r <= ack_r ? TW_WDATA : TW_WAIT_STOP;
                    end
                end
                TW_W_ACK: begin
                    if (scl_fall) begin
                        st_r <= TW_WDATA;
                    end
                end
                TW_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_r == TW_LAST_TX_BIT) begin
                            st_r  <= TW_RACK_CHK;
                            ptr_r <= sat_inc(ptr_r);
                        end else begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            cnt_r   <= cnt_r + 4'h1;
                        end
                    end
                end
                TW_RACK_CHK: begin
                    if (scl_rise) begin
                        st_r <= sda_s ? TW_WAIT_STOP : TW_RACK_OK;
                    end
                end
                TW_RACK_OK: begin
                    if (scl_fall) begin
                        st_r    <= TW_RDATA;
                        shift_r <= regs_r[ptr_r];
                        cnt_r   <= 4'h0;
                    end
                end
                default: st_r <= TW_IDLE;
            endcase
        end
    end

    // open drain: only ever pull low
    assign sda_o    = 1'b0;
    assign sda_oe_o = ((st_r == TW_A_ACK || st_r == TW_R_ACK || st_r == TW_W_ACK) && ack_r)
                      || (st_r == TW_RDATA && !shift_r[7]);

    // write events into the core clock domain
    tw_sync2 #(.W(1)) u_sync_core (
        .clk_i (clk_i),
        .d_i   (wr_tgl_l_r),
        .q_o   (wr_tgl_s)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_tgl_q_r    <= 1'b0;
            reg_wr_stb_o  <= 1'b0;
            reg_wr_addr_o <= 5'h00;
            reg_wr_data_o <= 8'h00;
        end else begin
            wr_tgl_q_r   <= wr_tgl_s;
            reg_wr_stb_o <= wr_tgl_s ^ wr_tgl_q_r;
            if (wr_tgl_s ^ wr_tgl_q_r) begin
                reg_wr_addr_o <= wr_addr_l_r;
                reg_wr_data_o <= wr_data_l_r;
            end
        end
    end

    default clocking cb @(posedge link_clk_i); endclocking
    // core reset also covers the first link edges, before the reset synchroniser has settled
    default disable iff (!lrst_b || !rst_b_i);

    sequence s_byte_done(tw_state_t s);
        st_r == s && scl_fall && cnt_r == TW_BYTE_BITS;
    endsequence

    sequence s_tx_load;
        ((st_r == TW_A_ACK && ack_r && rw_r) || st_r == TW_RACK_OK) && scl_fall
        && !start && !stop;
    endsequence

    property p_stop_idle;
        stop |=> st_r == TW_IDLE;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");

    property p_start_addr;
        start && !stop |=> st_r == TW_ADDR && cnt_r == 4'h0;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start not taken");

    property p_addr_ack;
        s_byte_done(TW_ADDR) |=> st_r == TW_A_ACK && ack_r == $past(addr_match);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");

    property p_big_nack;
        s_byte_done(TW_REGA) ##0 (shift_r > TW_REG_TOP_BYTE) |=> !ack_r ##0 !sda_oe_o;
    endproperty
    a_big_nack: assert property (p_big_nack) else $error("large address acked");

    property p_wr_inc;
        s_byte_done(TW_WDATA) |=> wr_addr_l_r == $past(ptr_r)
            && ptr_r == sat_inc($past(ptr_r));
    endproperty
    a_wr_inc: assert property (p_wr_inc) else $error("write address step wrong");

    property p_top;
        ptr_r <= TW_REG_TOP;
    endproperty
    a_top: assert property (p_top) else $error("address beyond top");

    property p_rd_nack;
        st_r == TW_RACK_CHK && scl_rise && sda_s |=> st_r == TW_WAIT_STOP ##1 !sda_oe_o;
    endproperty
    a_rd_nack: assert property (p_rd_nack) else $error("read nack ignored");

    property p_tx_msb;
        s_tx_load |=> st_r == TW_RDATA && sda_oe_o == !regs_r[$past(ptr_r)][7];
    endproperty
    a_tx_msb: assert property (p_tx_msb) else $error("read byte not msb first");

    property p_change_low;
        $changed(sda_oe_o) && !$past(start) && !$past(stop) |-> !$past(scl_s);
    endproperty
    a_change_low: assert property (p_change_low) else $error("data moved, clock high");

    property p_release;
        st_r == TW_IDLE || st_r == TW_WAIT_STOP || st_r == TW_RACK_CHK |-> !sda_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("data line held");
endmodule

/* tw_master.sv */
// two-wire bus master model: drives the serial clock and pulls the data line low
`timescale 1ns/10ps
module tw_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick();
        @(negedge clk_i);
    endtask
    // data changes only while the clock is low
    task automatic put_bit(input logic b);
        tick();
        sda_low_o = ~b;
        tick();
        scl_o = 1'b1;
        tick();
        tick();
        scl_o = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        tick();
        sda_low_o = 1'b0;
        tick();
        scl_o = 1'b1;
        tick();
        b = sda_i;
        tick();
        scl_o = 1'b0;
    endtask
    // also serves as repeated start from a low clock
    task automatic start();
        tick();
        sda_low_o = 1'b0;
        tick();
        scl_o = 1'b1;
        tick();
        sda_low_o = 1'b1;
        tick();
        scl_o = 1'b0;
    endtask
    task automatic stop();
        tick();
        sda_low_o = 1'b1;
        tick();
        scl_o = 1'b1;
        tick();
        sda_low_o = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ack = ~b;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(last);
    endtask
endmodule

/* two_wire_register_access_slave_tb.sv */
// self-checking bench of the serial slave against the master model
`timescale 1ns/10ps
module two_wire_register_access_slave_tb;
    import tw_pkg::*;
    logic              clk_i = 1'b0;
    logic              link_clk = 1'b0;
    logic              rst_b_i = 1'b0;
    logic [1:0]        pins = 2'h0;
    logic              scl, sda_low, sda, sda_o, sda_oe, stb;
    logic [TW_AW-1:0]  waddr;
    logic [TW_DW-1:0]  wdata;
    logic [12:0]       wq[$];
    logic [7:0]        shadow[TW_NUM_REGS];
    int                err_count = 0;
    int                num_checks = 0;
    int                cyc = 0;
    assign sda = ~(sda_low | (sda_oe & ~sda_o));
    tw_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    tw_slave uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .device_address_select_pins_i(pins), .reg_wr_stb_o(stb),
        .reg_wr_addr_o(waddr), .reg_wr_data_o(wdata));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        forever #3 link_clk = ~link_clk;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
    end
    always @(negedge clk_i) begin
        if (stb === 1'b1) begin
            if (wq.size() == 0) begin
                chk("wr_unexpected", 8'h00, 8'h01);
            end else begin
                chk("wr_addr", {3'h0, wq[0][12:8]}, {3'h0, waddr});
                chk("wr_data", wq[0][7:0], wdata);
                void'(wq.pop_front());
            end
        end
    end
    task automatic head(input logic [4:0] base, output logic [4:0] ptr);
        logic a;
        m.start();
        m.wbyte({TW_ADDR_HI, pins, 1'b0}, a);
        chk("ack_addr", 8'h01, {7'h0, a});
        m.wbyte({3'h0, base}, a);
        chk("ack_base", 8'h01, {7'h0, a});
        ptr = base;
    endtask
    task automatic wr_seq(input logic [4:0] base, input int n);
        logic [4:0] ptr;
        logic [7:0] d;
        logic       a;
        head(base, ptr);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            // note the write before sending it: the strobe arrives during the ack bit
            wq.push_back({ptr, d});
            shadow[ptr] = d;
            m.wbyte(d, a);
            chk("ack_data", 8'h01, {7'h0, a});
            if (ptr != TW_REG_TOP) ptr++;
        end
        m.stop();
    endtask
    task automatic rd_seq(input logic [4:0] base, input int n);
        logic [4:0] ptr;
        logic [7:0] d;
        logic       a;
        head(base, ptr);
        m.start();
        m.wbyte({TW_ADDR_HI, pins, 1'b1}, a);
        chk("ack_raddr", 8'h01, {7'h0, a});
        for (int i = 0; i < n; i++) begin
            m.rbyte(i == n - 1, d);
            chk("rd_data", shadow[ptr], d);
            if (ptr != TW_REG_TOP) ptr++;
        end
        m.tick();
        chk("sda_released", 8'h01, {7'h0, sda});
        m.stop();
    endtask
    initial begin
        logic [4:0] p;
        logic       a;
        for (int i = 0; i < TW_NUM_REGS; i++) shadow[i] = TW_REG_RESET;
        void'($urandom(84));
        repeat (5) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clk_i);
        rd_seq(5'h00, 2);
        for (int i = 0; i < 4; i++) begin
            pins = 2'(i);
            wr_seq(5'($urandom_range(0, 28)), 2);
        end
        pins = 2'($urandom);
        wr_seq(5'h1a, 6);
        rd_seq(5'h1b, 4);
        rd_seq(5'($urandom_range(0, 29)), 1);
        m.start();
        m.wbyte({TW_ADDR_HI, pins, 1'b0}, a);
        m.wbyte(TW_REG_TOP_BYTE + 8'h01, a);
        chk("nack_base", 8'h00, {7'h0, a});
        m.wbyte(8'($urandom), a);
        chk("nack_data", 8'h00, {7'h0, a});
        m.stop();
        m.start();
        m.wbyte({TW_ADDR_HI, ~pins, 1'b0}, a);
        chk("nack_other", 8'h00, {7'h0, a});
        m.stop();
        head(5'h05, p);
        for (int i = 0; i < 4; i++) m.put_bit(1'b1);
        m.stop();
        head(5'h06, p);
        for (int i = 0; i < 5; i++) m.put_bit(1'b0);
        m.start();
        m.stop();
        rd_seq(5'h05, 2);
        repeat (20) @(negedge clk_i);
        chk("wr_pending", 8'h00, 8'(wq.size()));
        print_verdict();
    end
endmodule
